// ==== pkg/sbsc_pkg.sv ====
package sbsc_pkg;
   // organisation: 32K words of four 9-bit lanes
   localparam int ADDR_W      = 15;
   localparam int LANES       = 4;
   localparam int LANE_W      = 9;
   localparam int DATA_W      = 36;
   localparam int BYTE_W      = 8;
   localparam int BURST_W     = 2;
   localparam int DEPTH       = 32768;
   // wake-up time after sleep, in clock cycles as printed
   localparam int WAKE_CYCLES = 2;
   localparam logic [1:0] WAKE_CNT = 2'(WAKE_CYCLES);
   // last step of a four-access burst
   localparam logic [1:0] BURST_LAST = 2'h3;
   // access kinds
   typedef enum logic [1:0]
   {
      SBSC_IDLE  = 2'b00,
      SBSC_READ  = 2'b01,
      SBSC_WRITE = 2'b10
   } sbsc_kind_t;
endpackage

// ==== rtl/sbsc_burst_ctr.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbsc_burst_ctr
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_load,
   input  wire logic       i_step,
   input  wire logic [1:0] i_start,
   input  wire logic       i_order,
   output logic      [1:0] o_low
);
   logic [1:0] start_reg;
   logic [1:0] start_next;
   logic [1:0] count_reg;
   logic [1:0] count_next;

   // count steps from the start value; wraps after four accesses
   always_comb
   begin
      start_next = start_reg;
      count_next = count_reg;
      if (i_load)
      begin
         start_next = i_start;
         count_next = 2'h0;
      end
      else if (i_step)
      begin
         count_next = count_reg + 2'h1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         start_reg <= 2'h0;
         count_reg <= 2'h0;
      end
      else
      begin
         start_reg <= start_next;
         count_reg <= count_next;
      end
   end

   // address of this edge's access: a step moves it at once; linear adds, interleaved xors
   assign o_low = i_order ? (start_next ^ count_next) : (start_next + count_next);
endmodule
`default_nettype wire

// ==== rtl/sbsc_lane_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbsc_lane_decode
(
   input  wire logic       i_full_width_write_n,
   input  wire logic       i_lane_write_enable_n,
   input  wire logic [3:0] i_lane_write_n,
   output logic      [3:0] o_lane_we,
   output logic            o_is_write
);
   // write table: full width wins, else selected lanes, else read
   always_comb
   begin
      if (!i_full_width_write_n)
      begin
         o_lane_we = 4'hF;
      end
      else if (!i_lane_write_enable_n)
      begin
         o_lane_we = ~i_lane_write_n;
      end
      else
      begin
         o_lane_we = 4'h0;
      end
      o_is_write = |o_lane_we;
   end
endmodule
`default_nettype wire

// ==== rtl/sbsc_top.sv ====
// Operation
// - inputs sampled on rising edge, except async ones; here sleep and output enable are sampled too
// - sleep holds state, data pins released
// - two wake-up cycles after sleep ends
// - read when write table decodes no write
// - read drives stored data when enabled
// - writes start from ctrl strobe only
// - full width write writes all lanes
// - lane enable writes lanes with low inputs
// - each lane write covers nine bits
// - primary select gates cpu strobe on loads
// - step ignored on cpu strobe edge taken with primary select low
// - step low advances burst address
// - counter starts from low bits, wraps
// - order low gives linear sequence
// - order high gives interleaved sequence
// - read begin and deselect decode
// - write begin needs all selects, ctrl strobe
// - no strobe and step low continues burst
// - no strobe and step high suspends burst
// - sleep and output enable qualify outcome
`timescale 1ns/1ps
`default_nettype none
module sbsc_top
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_cpu_addr_strobe_n,
   input  wire logic        i_ctrl_addr_strobe_n,
   input  wire logic        i_burst_step_n,
   input  wire logic        i_primary_select_n,
   input  wire logic        i_select_high_active,
   input  wire logic        i_select_low_active_n,
   input  wire logic        i_full_width_write_n,
   input  wire logic        i_lane_write_enable_n,
   input  wire logic [3:0]  i_lane_write_n,
   input  wire logic        i_output_enable_n,
   input  wire logic        i_sleep_request,
   input  wire logic        i_burst_order_select,
   input  wire logic [14:0] i_word_address,
   input  wire logic [35:0] i_data,
   output logic      [35:0] o_data,
   output logic      [35:0] o_data_oe,
   output logic             o_awake
);
   // storage: four lanes, each eight data bits and parity; the array
   // has no reset, so a read of a never written word returns unknowns
   // and a cache above must not trust it before a fill
   logic [sbsc_pkg::LANE_W-1:0] mem_lane [sbsc_pkg::LANES][sbsc_pkg::DEPTH];
   logic [sbsc_pkg::LANE_W-1:0] wr_lane [sbsc_pkg::LANES];
   logic [sbsc_pkg::LANE_W-1:0] rd_lane [sbsc_pkg::LANES];

   // one lane of a pin word: its parity bit above its eight data bits
   function automatic logic [8:0] lane_slice(input logic [35:0] word, input int lane);
      lane_slice = {word[32 + lane], word[lane * 8 +: 8]};
   endfunction

   // a pin word with one lane replaced by the given nine bits
   function automatic logic [35:0] lane_put(input logic [35:0] word, input int lane, input logic [8:0] bits);
      lane_put                = word;
      lane_put[lane * 8 +: 8] = bits[7:0];
      lane_put[32 + lane]     = bits[8];
   endfunction

   // cpu strobe loads always read; otherwise the write table decides
   function automatic sbsc_pkg::sbsc_kind_t kind_of(input logic cpu_load, input logic wr);
      kind_of = (cpu_load || !wr) ? sbsc_pkg::SBSC_READ : sbsc_pkg::SBSC_WRITE;
   endfunction

   // registered access state

   logic [14:0]          addr_reg;
   logic [14:0]          addr_next;
   sbsc_pkg::sbsc_kind_t kind_reg;
   sbsc_pkg::sbsc_kind_t kind_next;
   logic                 sel_reg;
   logic                 sel_next;
   logic [1:0]           wake_reg;
   logic [1:0]           wake_next;
   logic                 awake_reg;
   logic                 awake_next;
   logic [35:0]          rdata_reg;
   logic [35:0]          rdata_next;
   logic                 rvalid_reg;
   logic                 rvalid_next;
   logic [35:0]          dout_reg;
   logic [35:0]          oe_reg;
   logic [35:0]          oe_next;
   logic [35:0]          dout_next;

   // decoded controls of the current edge

   logic [3:0]  lane_we;
   logic        is_write;
   logic [1:0]  burst_low;
   logic        active;
   logic        sel_ok;
   logic        cpu_start;
   logic        ctrl_start;
   logic        load;
   logic        step;
   logic        deselect;
   logic [14:0] cur_addr;
   logic [3:0]  wr_en;
   logic [14:0] acc_addr;

   // write table: which lanes this edge would write
   sbsc_lane_decode u_decode
   (
      .i_full_width_write_n  (i_full_width_write_n),
      .i_lane_write_enable_n (i_lane_write_enable_n),
      .i_lane_write_n        (i_lane_write_n),
      .o_lane_we             (lane_we),
      .o_is_write            (is_write)
   );

   // burst low bits, linear or interleaved, wrapping after four
   sbsc_burst_ctr u_burst
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_load  (load),
      .i_step  (step),
      .i_start (i_word_address[1:0]),
      .i_order (i_burst_order_select),
      .o_low   (burst_low)
   );

   // wake countdown: sleep freezes everything, then two cycles pass;
   // a strobe inside that window is dropped, not queued
   always_comb
   begin
      if (i_sleep_request)
      begin
         wake_next = sbsc_pkg::WAKE_CNT;
      end
      else if (wake_reg != 2'h0)
      begin
         wake_next = wake_reg - 2'h1;
      end
      else
      begin
         wake_next = 2'h0;
      end
      // awake once sleep is low and the wake count has run out
      awake_next = !i_sleep_request && (wake_next == 2'h0);
   end

   // wake count and awake flag; reset loads the flag high directly,
   // alongside a zero count
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wake_reg  <= 2'h0;
         awake_reg <= 1'b1;
      end
      else
      begin
         wake_reg  <= wake_next;
         awake_reg <= awake_next;
      end
   end

   // strobe decode of the synchronous table
   // deselect needs a strobe; without one the burst state carries on
   always_comb
   begin
      active     = !i_sleep_request && (wake_reg == 2'h0);
      sel_ok     = !i_primary_select_n && i_select_high_active && !i_select_low_active_n;
      // cpu strobe only counts with primary select low
      cpu_start  = active && !i_cpu_addr_strobe_n && !i_primary_select_n;
      ctrl_start = active && i_cpu_addr_strobe_n && !i_ctrl_addr_strobe_n;
      load       = (cpu_start || ctrl_start) && sel_ok;
      deselect   = (cpu_start || ctrl_start) && !sel_ok;
      // no strobe taken: continue or suspend the burst
      // a taken strobe wins, so a cpu load edge ignores burst step
      step       = active && !(cpu_start || ctrl_start) && sel_reg && !i_burst_step_n;
      cur_addr   = {addr_reg[14:2], burst_low};
      // a load accesses the pin address, a burst the counted one
      // whose low bits already include this edge's step
      acc_addr   = load ? i_word_address : cur_addr;
   end

   // access state: registered address, kind and selection
   // everything holds while asleep or waking
   always_comb
   begin
      addr_next  = addr_reg;
      kind_next  = kind_reg;
      sel_next   = sel_reg;
      if (load)
      begin
         addr_next  = i_word_address;
         sel_next   = 1'b1;
         // cpu strobe always reads; ctrl strobe follows write table
         kind_next  = kind_of(!i_cpu_addr_strobe_n, is_write);
      end
      else if (deselect)
      begin
         sel_next  = 1'b0;
         kind_next = sbsc_pkg::SBSC_IDLE;
      end
      else if (active && sel_reg)
      begin
         // continue or suspend both re-decode the write table
         kind_next = kind_of(1'b0, is_write);
      end
   end

   // address, kind and selection registers
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         addr_reg  <= 15'h0000;
         kind_reg  <= sbsc_pkg::SBSC_IDLE;
         sel_reg   <= 1'b0;
      end
      else
      begin
         addr_reg  <= addr_next;
         kind_reg  <= kind_next;
         sel_reg   <= sel_next;
      end
   end

   // lane writes this edge: data and lanes taken with the address
   // a cpu strobe load never writes, whatever the write table says
   always_comb
   begin
      wr_en = 4'h0;
      if (active && !deselect)
      begin
         if (ctrl_start && sel_ok && !is_write)
         begin
            wr_en = 4'h0;
         end
         else if ((ctrl_start && sel_ok) || (!(cpu_start || ctrl_start) && sel_reg))
         begin
            wr_en = lane_we;
         end
      end
   end

   // write word cut into lanes, all taken on the edge of the access
   always_comb
   begin
      for (int l = 0; l < sbsc_pkg::LANES; l++)
      begin
         wr_lane[l] = lane_slice(i_data, l);
      end
   end

   // memory array, one writer per lane
   // each lane writes only its own slice, so the lanes never collide
   for (genvar g = 0; g < sbsc_pkg::LANES; g++)
   begin : g_lane
      always_ff @(posedge i_clk)
      begin
         if (wr_en[g])
         begin
            mem_lane[g][acc_addr] <= wr_lane[g];
         end
      end
   end

   // lanes of the accessed word, read straight from the array
   always_comb
   begin
      for (int l = 0; l < sbsc_pkg::LANES; l++)
      begin
         rd_lane[l] = mem_lane[l][acc_addr];
      end
   end

   // read data path: fetch at the accessed address; the word
   // leaves the pins one edge after the edge that took the read
   always_comb
   begin
      rdata_next  = rdata_reg;
      rvalid_next = rvalid_reg;
      if (active)
      begin
         rvalid_next = 1'b0;
         if ((load && kind_next == sbsc_pkg::SBSC_READ) || (!load && !deselect && sel_reg && !is_write))
         begin
            rvalid_next = 1'b1;
            for (int l = 0; l < sbsc_pkg::LANES; l++)
            begin
               rdata_next = lane_put(rdata_next, l, rd_lane[l]);
            end
         end
      end
   end

   // read data and its valid flag
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         rdata_reg  <= 36'h0_0000_0000;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // pin stage: output enable, sleep and wake gate the drivers;
   // drivers are all on or all off, never a partial word
   always_comb
   begin
      dout_next = rdata_reg;
      oe_next   = {36{rvalid_reg && !i_output_enable_n && active}};
   end

   // pin registers: outputs come straight from these flops
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         dout_reg <= 36'h0_0000_0000;
         oe_reg   <= 36'h0_0000_0000;
      end
      else
      begin
         dout_reg <= dout_next;
         oe_reg   <= oe_next;
      end
   end

   assign o_data    = dout_reg;
   assign o_data_oe = oe_reg;
   assign o_awake   = awake_reg;
endmodule
`default_nettype wire

// ==== dv/sbsc_top_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbsc_top_checker
(
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_cpu_addr_strobe_n,
   input wire logic        i_ctrl_addr_strobe_n,
   input wire logic        i_primary_select_n,
   input wire logic        i_select_high_active,
   input wire logic        i_select_low_active_n,
   input wire logic        i_full_width_write_n,
   input wire logic        i_lane_write_enable_n,
   input wire logic [3:0]  i_lane_write_n,
   input wire logic        i_output_enable_n,
   input wire logic        i_sleep_request,
   input wire logic [35:0] o_data_oe,
   input wire logic        o_awake
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // decoded request kinds
   wire sel = !i_primary_select_n && i_select_high_active && !i_select_low_active_n;
   wire rdd = i_full_width_write_n && (i_lane_write_enable_n || i_lane_write_n == 4'hF);
   wire go = sel && o_awake && !i_sleep_request;
   wire rd = go && !i_cpu_addr_strobe_n;
   wire wr = go && i_cpu_addr_strobe_n && !i_ctrl_addr_strobe_n && !i_full_width_write_n;
   wire idle = i_cpu_addr_strobe_n && i_ctrl_addr_strobe_n && !i_output_enable_n && rdd && !i_sleep_request;
   wire desel = !i_ctrl_addr_strobe_n && i_primary_select_n;
   sleep_hiz_a: assert property (i_sleep_request |=> o_data_oe == '0) else $error("drive in sleep");
   sleep_flag_a: assert property (i_sleep_request |=> !o_awake) else $error("awake in sleep");
   wake_time_a: assert property ($fell(i_sleep_request) |-> !o_awake ##1 !o_awake ##[1:3] o_awake)
      else $error("wake time wrong");
   oe_gate_a: assert property ($past(i_output_enable_n) |-> o_data_oe == '0) else $error("drive while off");
   lanes_even_a: assert property (o_data_oe == '0 || o_data_oe == '1) else $error("partial drive");
   read_drive_a: assert property (rd ##1 idle [*3] |-> o_data_oe == '1) else $error("read not driven");
   desel_quiet_a: assert property (desel ##1 idle [*3] |-> o_data_oe == '0) else $error("deselect drives");
   write_quiet_a: assert property (wr ##1 wr |=> o_data_oe == '0) else $error("write drives");
   cover property (rd);
   cover property (wr ##1 wr);
   cover property ($fell(i_sleep_request));
endmodule
bind sbsc_top sbsc_top_checker u_sbsc_top_checker (.*);
`default_nettype wire

// ==== dv/sbsc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbsc_host_model
(
   input  wire logic        i_clk,
   input  wire logic        i_drive,
   input  wire logic [35:0] i_wdata,
   input  wire logic [35:0] i_dev_oe,
   output logic      [35:0] o_pins,
   output logic             o_clash
);
   logic [35:0] last_reg = 36'h0;
   // released pins change every cycle, never keep the old value
   assign o_pins = i_drive ? i_wdata : ~last_reg;
   assign o_clash = i_drive && i_dev_oe != 36'h0;
   always_ff @(posedge i_clk) last_reg <= o_pins;
endmodule
`default_nettype wire

// ==== dv/sbsc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbsc_top_tb;
   logic        clk = 1'b0, rst = 1'b1, cpu_n = 1'b1, ctl_n = 1'b1, step_n = 1'b1, gw_n = 1'b1, bw_n = 1'b1;
   logic        p_n = 1'b0, s_hi = 1'b1, s_lo_n = 1'b0, oe_n = 1'b1, zz = 1'b0, ord = 1'b0, drv = 1'b0;
   logic [3:0]  we_n = 4'hF, lanes [6] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'h3, 4'h0};
   logic [14:0] adr = 15'h0;
   logic [35:0] wd = 36'h0, pins, rdat, doe, e[$], q[$], mem [logic [14:0]];
   logic        awake, clash;
   int          err_total = 0, checked = 0;
   localparam logic [14:0] B = 15'h5A0;
   always #50 clk = ~clk;
   sbsc_top u_sbsc_top (.i_clk(clk), .i_rst(rst), .i_cpu_addr_strobe_n(cpu_n), .i_ctrl_addr_strobe_n(ctl_n),
      .i_burst_step_n(step_n), .i_primary_select_n(p_n), .i_select_high_active(s_hi), .i_select_low_active_n(s_lo_n),
      .i_full_width_write_n(gw_n), .i_lane_write_enable_n(bw_n), .i_lane_write_n(we_n), .i_output_enable_n(oe_n),
      .i_sleep_request(zz), .i_burst_order_select(ord), .i_word_address(adr), .i_data(pins), .o_data(rdat),
      .o_data_oe(doe), .o_awake(awake));
   sbsc_host_model u_sbsc_host_model (.i_clk(clk), .i_drive(drv), .i_wdata(wd), .i_dev_oe(doe), .o_pins(pins),
      .o_clash(clash));
   // collect every driven word, flag contention
   always @(posedge clk)
   begin
      if (doe === '1)
         q.push_back(rdat);
      if (clash === 1'b1)
         chk(36'h1, 36'h0, "bus clash");
   end
   task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string m);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one cycle of pins; host drives data and turns output enable off on writes
   task automatic put(input logic c, t, s, g, b, input logic [3:0] w, input logic [14:0] a, input logic [35:0] d);
      @(negedge clk);
      {cpu_n, ctl_n, step_n, gw_n, bw_n, we_n, adr, wd} = {c, t, s, g, b, w, a, d};
      drv = !g || (!b && w != 4'hF);
      oe_n = drv;
   endtask
   task automatic mw(input logic [14:0] a, input logic [35:0] d, input logic g, b, input logic [3:0] w);
      for (int l = 0; l < 4; l++)
         if (!g || (!b && !w[l]))
         begin
            mem[a][8*l+:8] = d[8*l+:8];
            mem[a][32+l] = d[32+l];
         end
   endtask
   // deselect, drain, compare collected words
   task automatic quiet();
      put(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 15'h0, 36'h0);
      p_n = 1'b1;
      repeat (4) put(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 15'h0, 36'h0);
      p_n = 1'b0;
      foreach (e[k]) chk(q[k], e[k], "read word");
      chk(36'(q.size()), 36'(e.size()), "word count");
      q.delete();
      e.delete();
   endtask
   task automatic rb(input logic c, input logic [14:0] a, input int n, input logic h);
      put(c, !c, c, 1'b1, !c, 4'hF, a, 36'h0);
      if (h) put(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 15'h0, 36'h0);
      for (int k = 1; k < n; k++) put(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF, 15'h0, 36'h0);
      for (int k = 0; k < n; k++)
      begin
         e.push_back(mem[{a[14:2], ord ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)}]);
         if (h && k == 0) e.push_back(mem[a]);
      end
      quiet();
   endtask
   initial
   begin
      repeat (2000) @(posedge clk);
      err_total++;
      print_verdict();
   end
   initial
   begin
      logic [35:0] d;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 32; i++)
      begin
         d = 36'(i) * 36'h2_0304_0507;
         put(1'b1, 1'b0, 1'b1, 1'b0, i[0], 4'(i), B + 15'(i), d);
         mw(B + 15'(i), d, 1'b0, 1'b1, 4'hF);
      end
      for (int i = 0; i < 6; i++)
      begin
         d = ~(36'(i) * 36'h3_0507_0B0D);
         put(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, lanes[i], B + 15'(i), d);
         mw(B + 15'(i), d, 1'b1, 1'b0, lanes[i]);
      end
      put(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, B + 15'h8, 36'hF_1111_1111);
      put(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 15'h0, 36'hE_2222_2222);
      put(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'h6, 15'h0, 36'hD_3333_3333);
      mw(B + 15'h8, 36'hF_1111_1111, 1'b0, 1'b1, 4'hF);
      mw(B + 15'h9, 36'hE_2222_2222, 1'b0, 1'b1, 4'hF);
      mw(B + 15'h9, 36'hD_3333_3333, 1'b1, 1'b0, 4'h6);
      quiet();
      $display("test writes done");
      rb(1'b1, B + 15'h1, 6, 1'b0);
      ord = 1'b1;
      rb(1'b1, B + 15'h9, 4, 1'b0);
      rb(1'b0, B + 15'h6, 4, 1'b0);
      ord = 1'b0;
      rb(1'b0, B + 15'hB, 4, 1'b1);
      $display("test bursts done");
      for (int j = 0; j < 6; j++)
      begin
         put(j < 3, j > 2, 1'b1, 1'b0, 1'b1, 4'hF, B, 36'h0);
         {p_n, s_hi, s_lo_n} = {j % 3 == 0, j % 3 != 1, j % 3 == 2};
         quiet();
         {s_hi, s_lo_n} = 2'b10;
      end
      $display("test deselect done");
      zz = 1'b1;
      repeat (3) put(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, B + 15'h2, 36'h0);
      chk(36'(awake), 36'h0, "awake in sleep");
      zz = 1'b0;
      put(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, B + 15'h2, 36'h0);
      quiet();
      chk(36'(awake), 36'h1, "not awake");
      rb(1'b1, B, 4, 1'b0);
      $display("test sleep done");
      print_verdict();
   end
endmodule
`default_nettype wire
